// file: verilog/mfs_defines.vh
// Constants for the management fault supervisor
// What this block does
// - Load timestamp from battery clock after reset
// - OS time changes leave timestamp untouched
// - Event log reachable in every power state
// - Log holds 3639 records in 95231 bytes
// - Overflowing log command refused with C4h
// - Sensor repository 65519 bytes, always reachable
// - Beep code once per detection, never repeated
// - Each digit sounds as that many beeps
// - Codes 1-5-2-1 no processor, 1-5-2-4 identity
// - Codes 1-5-4-2 dropout, 1-5-4-4 power timeout
// - Codes 1-5-1-2 regulator watchdog, 1-5-1-4 supply
// - Diagnostic interrupt pulse lasts at least 30 ms
// - One pulse only until system reset
// - Pulse on command, button, or pre-timeout
// - Log button and watchdog pulses unless a controller reset is logged that cycle; not command
// - Watchdog restarts CPU, hardware, or firmware
// - At most three hardware or CPU resets, then hold boot loader
// - Reset count clears after 30 quiet minutes
// - Log each watchdog-caused controller reset
// - Degraded status held until system reset
`ifndef MFS_DEFINES_VH
`define MFS_DEFINES_VH
`define MFS_CLK_MHZ 125
`define MFS_LOG_MAX_RECORDS 3639
`define MFS_LOG_MAX_BYTES 95231
`define MFS_REPO_MAX_BYTES 65519
`define MFS_CC_OK 8'h00
`define MFS_CC_OUT_OF_SPACE 8'hc4
`define MFS_NMI_MS 30
`define MFS_NMI_CYCLES (`MFS_NMI_MS * 1000 * `MFS_CLK_MHZ)
`define MFS_QUIET_MIN 30
`define MFS_QUIET_CYCLES (64'd`MFS_QUIET_MIN * 64'd60 * 64'd1000000 * 64'd`MFS_CLK_MHZ + 64'd1)
`define MFS_WDT_MAX_RESETS 3
`define MFS_BEEP_ON_MS 200
`define MFS_BEEP_GAP_MS 200
`define MFS_DIGIT_GAP_MS 1000
`define MFS_MS_CYCLES(ms) ((ms) * 1000 * `MFS_CLK_MHZ)
`define MFS_CODE_NO_CPU 16'h1521
`define MFS_CODE_ID_MISMATCH 16'h1524
`define MFS_CODE_PG_DROP 16'h1542
`define MFS_CODE_PG_TIMEOUT 16'h1544
`define MFS_CODE_VR_WDT 16'h1512
`define MFS_CODE_PSU_MIX 16'h1514
`define MFS_EVT_NMI_BUTTON 2'd1
`define MFS_EVT_NMI_WDT 2'd2
`define MFS_EVT_CTRL_RESET 2'd3
`define MFS_RST_NONE 2'd0
`define MFS_RST_FW 2'd1
`define MFS_RST_HW 2'd2
`define MFS_RST_CPU 2'd3
`endif

// file: verilog/mfs_beep_seq.v
// Beep code sequencer: up to four BCD digits, one group of beeps per digit; a zero digit ends the code
`timescale 1ns/100ps
`include "mfs_defines.vh"
module mfs_beep_seq #(
  parameter BEEP_ON = `MFS_MS_CYCLES(`MFS_BEEP_ON_MS),
  parameter BEEP_GAP = `MFS_MS_CYCLES(`MFS_BEEP_GAP_MS),
  parameter DIGIT_GAP = `MFS_MS_CYCLES(`MFS_DIGIT_GAP_MS)
)(
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [15:0] code,
  output wire busy,
  output reg beep
);
  localparam S_IDLE = 2'd0;
  localparam S_ON = 2'd1;
  localparam S_GAP = 2'd2;
  localparam S_DGAP = 2'd3;
  reg [1:0] state;
  reg [15:0] shift;
  reg [1:0] digit_idx;
  reg [3:0] left;
  reg [31:0] timer;
  assign busy = (state != S_IDLE);
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      shift <= 16'h0000;
      digit_idx <= 2'd0;
      left <= 4'h0;
      timer <= 32'h00000000;
      beep <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          beep <= 1'b0;
          // Started once per detection, never loops back by itself
          if (start && code[15:12] != 4'h0)
          begin
            shift <= {code[11:0], 4'h0};
            left <= code[15:12];
            digit_idx <= 2'd0;
            timer <= BEEP_ON[31:0] - 32'd1;
            beep <= 1'b1;
            state <= S_ON;
          end
        end
        S_ON:
          if (timer == 32'd0)
          begin
            beep <= 1'b0;
            left <= left - 4'h1;
            if (left != 4'h1)
            begin
              timer <= BEEP_GAP[31:0] - 32'd1;
              state <= S_GAP;
            end
            else if (digit_idx == 2'd3)
              state <= S_IDLE;
            else
            begin
              timer <= DIGIT_GAP[31:0] - 32'd1;
              state <= S_DGAP;
            end
          end
          else
            timer <= timer - 32'd1;
        S_GAP:
          if (timer == 32'd0)
          begin
            timer <= BEEP_ON[31:0] - 32'd1;
            beep <= 1'b1;
            state <= S_ON;
          end
          else
            timer <= timer - 32'd1;
        S_DGAP:
          if (timer == 32'd0)
          begin
            digit_idx <= digit_idx + 2'd1;
            left <= shift[15:12];
            shift <= {shift[11:0], 4'h0};
            timer <= BEEP_ON[31:0] - 32'd1;
            beep <= (shift[15:12] != 4'h0);
            state <= (shift[15:12] != 4'h0) ? S_ON : S_IDLE;
          end
          else
            timer <= timer - 32'd1;
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// file: verilog/mfs_occupancy.v
// Occupancy tracker for one non-volatile store, refuses overflow
`timescale 1ns/100ps
`include "mfs_defines.vh"
module mfs_occupancy #(
  parameter MAX_BYTES = `MFS_LOG_MAX_BYTES,
  parameter MAX_RECORDS = `MFS_LOG_MAX_RECORDS
)(
  input wire clk_sys,
  input wire rst,
  input wire req_valid,
  input wire req_add,
  input wire req_clear,
  input wire [15:0] req_bytes,
  output reg done,
  output reg [7:0] completion,
  output reg [16:0] used_bytes,
  output reg [15:0] used_records
);
  wire [17:0] grown = {1'b0, used_bytes} + {2'b00, req_bytes};
  wire fits = (grown <= MAX_BYTES) &&
    ({1'b0, used_records} + 17'd1 <= MAX_RECORDS);
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      done <= 1'b0;
      completion <= `MFS_CC_OK;
      used_bytes <= 17'd0;
      used_records <= 16'd0;
    end
    else
    begin
      done <= req_valid;
      if (req_valid)
      begin
        if (req_clear)
        begin
          used_bytes <= 17'd0;
          used_records <= 16'd0;
          completion <= `MFS_CC_OK;
        end
        else if (req_add && !fits)
          completion <= `MFS_CC_OUT_OF_SPACE;
        else if (req_add)
        begin
          used_bytes <= grown[16:0];
          used_records <= used_records + 16'd1;
          completion <= `MFS_CC_OK;
        end
        else
          completion <= `MFS_CC_OK;
      end
    end
  end
endmodule

// file: verilog/mfs_supervisor.v
// Management fault supervisor top: time, stores, beeps, NMI, watchdog
`timescale 1ns/100ps
`include "mfs_defines.vh"
module mfs_supervisor #(
  parameter NMI_CYCLES = `MFS_NMI_CYCLES,
  parameter [63:0] QUIET_CYCLES = `MFS_QUIET_CYCLES,
  parameter BEEP_ON = `MFS_MS_CYCLES(`MFS_BEEP_ON_MS),
  parameter BEEP_GAP = `MFS_MS_CYCLES(`MFS_BEEP_GAP_MS),
  parameter DIGIT_GAP = `MFS_MS_CYCLES(`MFS_DIGIT_GAP_MS),
  parameter TICKS_PER_SEC = `MFS_CLK_MHZ * 1000000
)(
  input wire clk_sys,
  input wire rst,
  input wire sys_reset,
  // Battery clock read over the SMBus engine
  output reg rtc_read_req,
  input wire rtc_read_done,
  input wire [31:0] rtc_read_time,
  input wire time_set_valid,
  input wire [31:0] time_set_value,
  input wire os_time_change,
  output reg [31:0] timestamp,
  output reg time_valid,
  // Event log store requests (in-band or out-of-band alike)
  input wire log_req_valid,
  input wire log_req_add,
  input wire log_req_clear,
  input wire [15:0] log_req_bytes,
  output wire log_done,
  output wire [7:0] log_completion,
  output wire [15:0] log_records,
  // Sensor repository store requests
  input wire repo_req_valid,
  input wire repo_req_add,
  input wire repo_req_clear,
  input wire [15:0] repo_req_bytes,
  output wire repo_done,
  output wire [7:0] repo_completion,
  // Failure detections
  input wire fail_no_cpu,
  input wire fail_processor_identity_check,
  input wire fail_pg_dropout,
  input wire fail_pg_timeout,
  input wire fail_vr_watchdog,
  input wire fail_psu_mix,
  output wire beep,
  output wire beep_busy,
  // Diagnostic interrupt
  input wire nmi_cmd,
  input wire nmi_button,
  input wire wdt_pretimeout,
  input wire wdt_pretimeout_nmi_en,
  output reg nmi_out,
  // Self-recovery watchdog
  input wire wdt_fault,
  input wire [1:0] wdt_fault_kind,
  output reg [1:0] restart_kind,
  output reg restart_pulse,
  output reg boot_loader_stage,
  output reg [1:0] wdt_reset_count,
  output reg status_degraded,
  // Sensor event log output
  output reg event_valid,
  output reg [1:0] event_code
);
  localparam T_LOAD = 2'd0;
  localparam T_WAIT = 2'd1;
  localparam T_RUN = 2'd2;

  reg [1:0] t_state;
  reg [31:0] sec_div;
  reg nmi_used;
  reg [31:0] nmi_timer;
  reg [63:0] quiet_timer;
  reg fail_seen [0:5];
  reg beep_start;
  reg [15:0] beep_code;
  reg [2:0] pend_sel;
  reg next_rtc_req;
  wire [5:0] fail_in = {fail_psu_mix, fail_vr_watchdog, fail_pg_timeout,
    fail_pg_dropout, fail_processor_identity_check, fail_no_cpu};
  wire [5:0] fail_rise;
  wire [16:0] log_used_bytes;
  wire [16:0] repo_used_bytes;
  wire [15:0] repo_records;

  function [15:0] code_of;
    input [2:0] idx;
    begin
      case (idx)
        3'd0: code_of = `MFS_CODE_NO_CPU;
        3'd1: code_of = `MFS_CODE_ID_MISMATCH;
        3'd2: code_of = `MFS_CODE_PG_DROP;
        3'd3: code_of = `MFS_CODE_PG_TIMEOUT;
        3'd4: code_of = `MFS_CODE_VR_WDT;
        3'd5: code_of = `MFS_CODE_PSU_MIX;
        default: code_of = 16'h0000;
      endcase
    end
  endfunction

  // Timestamp: loaded from battery clock, then counted in seconds
  // Request stands until the battery clock answers
  always @*
  begin
    next_rtc_req = (t_state == T_LOAD) ||
      (t_state == T_WAIT && !rtc_read_done);
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      t_state <= T_LOAD;
      rtc_read_req <= 1'b0;
      timestamp <= 32'h00000000;
      time_valid <= 1'b0;
      sec_div <= 32'h00000000;
    end
    else
    begin
      rtc_read_req <= next_rtc_req;
      case (t_state)
        T_LOAD:
          t_state <= T_WAIT;
        T_WAIT:
          if (rtc_read_done)
          begin
            timestamp <= rtc_read_time;
            time_valid <= 1'b1;
            sec_div <= 32'h00000000;
            t_state <= T_RUN;
          end
        T_RUN:
        begin
          // OS time changes are deliberately not an input to this path
          if (time_set_valid)
          begin
            timestamp <= time_set_value;
            sec_div <= 32'h00000000;
          end
          else if (sec_div == TICKS_PER_SEC - 1)
          begin
            sec_div <= 32'h00000000;
            timestamp <= timestamp + 32'd1;
          end
          else
            sec_div <= sec_div + 32'd1;
        end
        default:
          t_state <= T_LOAD;
      endcase
    end
  end

  // Stores run from the controller clock only, so every power state
  mfs_occupancy #(
    .MAX_BYTES(`MFS_LOG_MAX_BYTES),
    .MAX_RECORDS(`MFS_LOG_MAX_RECORDS)
  ) u_log (
    .clk_sys(clk_sys),
    .rst(rst),
    .req_valid(log_req_valid),
    .req_add(log_req_add),
    .req_clear(log_req_clear),
    .req_bytes(log_req_bytes),
    .done(log_done),
    .completion(log_completion),
    .used_bytes(log_used_bytes),
    .used_records(log_records)
  );

  mfs_occupancy #(
    .MAX_BYTES(`MFS_REPO_MAX_BYTES),
    .MAX_RECORDS(65535)
  ) u_repo (
    .clk_sys(clk_sys),
    .rst(rst),
    .req_valid(repo_req_valid),
    .req_add(repo_req_add),
    .req_clear(repo_req_clear),
    .req_bytes(repo_req_bytes),
    .done(repo_done),
    .completion(repo_completion),
    .used_bytes(repo_used_bytes),
    .used_records(repo_records)
  );

  // Edge detect each failure; one code per detection
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_fail
      always @(posedge clk_sys)
      begin
        if (rst)
          fail_seen[g] <= 1'b0;
        else
          fail_seen[g] <= fail_in[g];
      end
      assign fail_rise[g] = fail_in[g] && !fail_seen[g];
    end
  endgenerate

  // Pending flags: new detection sets, start of its code clears
  reg [5:0] pend;
  always @*
  begin
    pend_sel = 3'd7;
    if (pend[5]) pend_sel = 3'd5;
    if (pend[4]) pend_sel = 3'd4;
    if (pend[3]) pend_sel = 3'd3;
    if (pend[2]) pend_sel = 3'd2;
    if (pend[1]) pend_sel = 3'd1;
    if (pend[0]) pend_sel = 3'd0;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend <= 6'h00;
      beep_start <= 1'b0;
      beep_code <= 16'h0000;
    end
    else
    begin
      beep_start <= 1'b0;
      if (!beep_busy && !beep_start && pend_sel != 3'd7)
      begin
        beep_start <= 1'b1;
        beep_code <= code_of(pend_sel);
        // Set wins over clear for the same slot
        pend <= (pend & ~(6'h01 << pend_sel)) | fail_rise;
      end
      else
        pend <= pend | fail_rise;
    end
  end

  mfs_beep_seq #(
    .BEEP_ON(BEEP_ON),
    .BEEP_GAP(BEEP_GAP),
    .DIGIT_GAP(DIGIT_GAP)
  ) u_beep (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(beep_start),
    .code(beep_code),
    .busy(beep_busy),
    .beep(beep)
  );

  // Diagnostic interrupt: one pulse per system reset
  wire nmi_wdt = wdt_pretimeout && wdt_pretimeout_nmi_en;
  wire nmi_trig = nmi_cmd || nmi_button || nmi_wdt;
  always @(posedge clk_sys)
  begin
    if (rst || sys_reset)
    begin
      nmi_used <= 1'b0;
      nmi_out <= 1'b0;
      nmi_timer <= 32'h00000000;
    end
    else if (nmi_out)
    begin
      if (nmi_timer == 32'd0)
        nmi_out <= 1'b0;
      else
        nmi_timer <= nmi_timer - 32'd1;
    end
    else if (nmi_trig && !nmi_used)
    begin
      nmi_used <= 1'b1;
      nmi_out <= 1'b1;
      nmi_timer <= NMI_CYCLES - 1;
    end
  end

  // Self-recovery watchdog
  wire wdt_take = wdt_fault && wdt_fault_kind != `MFS_RST_NONE &&
    !boot_loader_stage;
  wire ctrl_reset = wdt_take && wdt_fault_kind != `MFS_RST_FW;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      restart_kind <= `MFS_RST_NONE;
      restart_pulse <= 1'b0;
      boot_loader_stage <= 1'b0;
      wdt_reset_count <= 2'd0;
      quiet_timer <= 64'd0;
    end
    else
    begin
      restart_pulse <= wdt_take;
      if (wdt_take)
        restart_kind <= wdt_fault_kind;
      if (ctrl_reset)
      begin
        quiet_timer <= 64'd0;
        if (wdt_reset_count == `MFS_WDT_MAX_RESETS)
        begin
          restart_pulse <= 1'b0;
          boot_loader_stage <= 1'b1;
        end
        else
          wdt_reset_count <= wdt_reset_count + 2'd1;
      end
      else if (quiet_timer >= QUIET_CYCLES - 64'd1)
      begin
        wdt_reset_count <= 2'd0;
        quiet_timer <= 64'd0;
      end
      else if (!boot_loader_stage)
        quiet_timer <= quiet_timer + 64'd1;
    end
  end

  wire ctrl_reset_done = ctrl_reset &&
    wdt_reset_count != `MFS_WDT_MAX_RESETS;
  always @(posedge clk_sys)
  begin
    if (rst || sys_reset)
      status_degraded <= 1'b0;
    else if (ctrl_reset_done)
      status_degraded <= 1'b1;
  end

  // Sensor events; watchdog resets outrank interrupt events
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      event_valid <= 1'b0;
      event_code <= 2'd0;
    end
    else
    begin
      event_valid <= 1'b0;
      if (ctrl_reset_done)
      begin
        event_valid <= 1'b1;
        event_code <= `MFS_EVT_CTRL_RESET;
      end
      else if (!nmi_out && !nmi_used && (nmi_button || nmi_wdt))
      begin
        event_valid <= 1'b1;
        event_code <= nmi_button ? `MFS_EVT_NMI_BUTTON : `MFS_EVT_NMI_WDT;
      end
    end
  end
endmodule

// file: tb/mfs_supervisor_properties.sv
// Port-level checks for the management fault supervisor
`timescale 1ns/100ps
module mfs_sup_properties #(
  parameter NMI_CYCLES = 10,
  parameter BEEP_ON = 3
)(
  input wire clk_sys,
  input wire rst,
  input wire sys_reset,
  input wire rtc_read_req,
  input wire rtc_read_done,
  input wire [31:0] rtc_read_time,
  input wire [31:0] timestamp,
  input wire time_valid,
  input wire log_done,
  input wire [7:0] log_completion,
  input wire [15:0] log_records,
  input wire beep,
  input wire nmi_out,
  input wire nmi_button,
  input wire wdt_fault,
  input wire [1:0] wdt_fault_kind,
  input wire [1:0] restart_kind,
  input wire restart_pulse,
  input wire boot_loader_stage,
  input wire [1:0] wdt_reset_count,
  input wire status_degraded,
  input wire event_valid,
  input wire [1:0] event_code
);
  reg [7:0] hi_cnt;
  reg [7:0] beep_cnt;
  reg nmi_used;
  // Lockout seen from outside: set once a pulse has ended
  always @(posedge clk_sys)
  begin
    hi_cnt <= nmi_out ? hi_cnt + 8'h01 : 8'h00;
    beep_cnt <= beep ? beep_cnt + 8'h01 : 8'h00;
    if (rst || sys_reset)
      nmi_used <= 1'h0;
    else if (!nmi_out && hi_cnt != 8'h00)
      nmi_used <= 1'h1;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence counted_live;
    wdt_fault && wdt_fault_kind[1] && !boot_loader_stage
      && wdt_reset_count != 2'h3;
  endsequence
  sequence counted_last;
    wdt_fault && wdt_fault_kind[1] && !boot_loader_stage
      && wdt_reset_count == 2'h3;
  endsequence
  a_time_load: assert property (
    rtc_read_req && rtc_read_done
    |=> time_valid && timestamp == $past(rtc_read_time))
    else $error("timestamp not loaded");
  a_store_refuse: assert property (
    log_done && log_completion == 8'hc4 |-> $stable(log_records))
    else $error("refused add changed the log");
  a_beep_width: assert property (
    $fell(beep) |-> beep_cnt == BEEP_ON)
    else $error("beep length wrong");
  a_nmi_width: assert property (
    $fell(nmi_out) |-> hi_cnt >= NMI_CYCLES)
    else $error("diagnostic pulse too short");
  a_nmi_once: assert property (
    nmi_used |-> !nmi_out)
    else $error("second diagnostic pulse");
  a_nmi_button_log: assert property (
    $rose(nmi_out) && $past(nmi_button)
    |-> event_valid && event_code == 2'h1)
    else $error("button pulse not logged");
  a_wdt_restart: assert property (
    wdt_fault && wdt_fault_kind != 2'h0 && !boot_loader_stage
      && (wdt_reset_count != 2'h3 || !wdt_fault_kind[1])
    |=> restart_pulse && restart_kind == $past(wdt_fault_kind))
    else $error("restart missing");
  a_wdt_give_up: assert property (
    counted_last |=> boot_loader_stage && !restart_pulse)
    else $error("fourth reset not refused");
  a_wdt_logged: assert property (
    counted_live |=> event_valid && event_code == 2'h3 && status_degraded)
    else $error("counted reset not logged");
endmodule
bind mfs_supervisor mfs_sup_properties #(
  .NMI_CYCLES(NMI_CYCLES),
  .BEEP_ON(BEEP_ON)
) u_mfs_sup_properties (
  .clk_sys, .rst, .sys_reset, .rtc_read_req, .rtc_read_done,
  .rtc_read_time, .timestamp, .time_valid, .log_done, .log_completion,
  .log_records, .beep, .nmi_out, .nmi_button, .wdt_fault,
  .wdt_fault_kind, .restart_kind, .restart_pulse, .boot_loader_stage,
  .wdt_reset_count, .status_degraded, .event_valid, .event_code
);

// file: tb/mfs_host_model.sv
// Battery clock responder and host firmware time sync
`timescale 1ns/100ps
module mfs_host_model #(
  parameter [31:0] RTC_TIME = 32'h1234_5678,
  parameter [31:0] SET_TIME = 32'h0000_1000,
  parameter DELAY = 5
)(
  input wire clk_sys,
  input wire rst,
  input wire rtc_read_req,
  input wire time_valid,
  output reg rtc_read_done,
  output reg [31:0] rtc_read_time,
  output reg time_set_valid,
  output reg [31:0] time_set_value
);
  reg [7:0] wait_cnt;
  reg synced;
  always @(posedge clk_sys)
  begin
    rtc_read_done <= 1'h0;
    time_set_valid <= 1'h0;
    // Idle data toggles so stale values never look valid
    rtc_read_time <= ~rtc_read_time;
    time_set_value <= ~time_set_value;
    if (rst)
    begin
      wait_cnt <= 8'h00;
      synced <= 1'h0;
      rtc_read_time <= 32'h0f0f_0f0f;
      time_set_value <= 32'hf0f0_f0f0;
    end
    else
    begin
      if (rtc_read_req && !rtc_read_done)
      begin
        wait_cnt <= wait_cnt + 8'h01;
        if (wait_cnt == DELAY)
        begin
          rtc_read_done <= 1'h1;
          rtc_read_time <= RTC_TIME;
        end
      end
      if (time_valid && !synced)
      begin
        synced <= 1'h1;
        time_set_valid <= 1'h1;
        time_set_value <= SET_TIME;
      end
    end
  end
endmodule

// file: tb/mfs_supervisor_tb.sv
// Self-checking bench for the management fault supervisor
`timescale 1ns/100ps
module mfs_supervisor_tb;
  localparam [31:0] RTC = 32'h5a3c_0001;
  localparam [31:0] SET = 32'h0000_2000;
  localparam [95:0] CODES = 96'h1514_1512_1544_1542_1524_1521;
  reg clk_sys = 1'h0;
  reg rst = 1'h1;
  reg sys_reset = 1'h0;
  reg os_time_change = 1'h0;
  reg [1:0] st_valid = 2'h0;
  reg st_add = 1'h0;
  reg st_clear = 1'h0;
  reg [15:0] st_bytes = 16'h0;
  reg [5:0] fails = 6'h0;
  reg nmi_cmd = 1'h0;
  reg nmi_button = 1'h0;
  reg wdt_pretimeout = 1'h0;
  reg wdt_pretimeout_nmi_en = 1'h0;
  reg wdt_fault = 1'h0;
  reg [1:0] wdt_fault_kind = 2'h0;
  integer n_errors = 0;
  integer check_count = 0;
  integer cycles = 0;
  wire rtc_read_req, rtc_read_done, time_set_valid, time_valid;
  wire [31:0] rtc_read_time, time_set_value, timestamp;
  wire log_done, repo_done, beep, beep_busy, nmi_out;
  wire [7:0] log_completion, repo_completion;
  wire [15:0] log_records;
  wire [1:0] restart_kind, wdt_reset_count, event_code;
  wire restart_pulse, boot_loader_stage, status_degraded, event_valid;
  mfs_supervisor #(
    .NMI_CYCLES(10), .QUIET_CYCLES(64'h64), .BEEP_ON(3),
    .BEEP_GAP(3), .DIGIT_GAP(10)
  ) u_mfs_supervisor (
    .clk_sys, .rst, .sys_reset, .rtc_read_req, .rtc_read_done,
    .rtc_read_time, .time_set_valid, .time_set_value, .os_time_change,
    .timestamp, .time_valid,
    .log_req_valid(st_valid[0]), .log_req_add(st_add),
    .log_req_clear(st_clear), .log_req_bytes(st_bytes), .log_done,
    .log_completion, .log_records,
    .repo_req_valid(st_valid[1]), .repo_req_add(st_add),
    .repo_req_clear(st_clear), .repo_req_bytes(st_bytes), .repo_done,
    .repo_completion,
    .fail_no_cpu(fails[0]), .fail_processor_identity_check(fails[1]),
    .fail_pg_dropout(fails[2]), .fail_pg_timeout(fails[3]),
    .fail_vr_watchdog(fails[4]), .fail_psu_mix(fails[5]),
    .beep, .beep_busy, .nmi_cmd, .nmi_button, .wdt_pretimeout,
    .wdt_pretimeout_nmi_en, .nmi_out, .wdt_fault, .wdt_fault_kind,
    .restart_kind, .restart_pulse, .boot_loader_stage, .wdt_reset_count,
    .status_degraded, .event_valid, .event_code
  );
  mfs_host_model #(.RTC_TIME(RTC), .SET_TIME(SET)) u_mfs_host_model (
    .clk_sys, .rst, .rtc_read_req, .time_valid, .rtc_read_done,
    .rtc_read_time, .time_set_valid, .time_set_value
  );
  always #4 clk_sys = ~clk_sys;
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task t_time;
    integer k;
  begin
    for (k = 0; k < 50 && time_valid !== 1'h1; k = k + 1)
      @(negedge clk_sys);
    chk("timestamp", RTC, timestamp);
    chk("rtc_read_req", 0, rtc_read_req);
    repeat (4) @(negedge clk_sys);
    os_time_change = 1'h1;
    @(negedge clk_sys);
    os_time_change = 1'h0;
    repeat (2) @(negedge clk_sys);
    // Full-second tick is far off, so the value must be exact
    chk("synced", SET, timestamp);
  end
  endtask
  task store(input [1:0] sel, input clr, input [15:0] nb, input [7:0] cc);
  begin
    st_valid = sel;
    st_add = ~clr;
    st_clear = clr;
    st_bytes = nb;
    @(negedge clk_sys);
    // Done stands for one cycle only
    chk("done", 1, sel[0] ? log_done : repo_done);
    chk("completion", cc, sel[0] ? log_completion : repo_completion);
    st_valid = 2'h0;
    @(negedge clk_sys);
  end
  endtask
  task t_store;
    integer k;
  begin
    store(2'h1, 1'h0, 16'hffff, 8'h00);
    store(2'h1, 1'h0, 16'hffff, 8'hc4);
    store(2'h1, 1'h0, 16'h7400, 8'h00);
    store(2'h1, 1'h0, 16'h0001, 8'hc4);
    chk("records", 2, log_records);
    store(2'h1, 1'h1, 16'h0000, 8'h00);
    chk("records", 0, log_records);
    for (k = 0; k < 3639; k = k + 1)
      store(2'h1, 1'h0, 16'h0001, 8'h00);
    store(2'h1, 1'h0, 16'h0001, 8'hc4);
    chk("records", 3639, log_records);
    store(2'h2, 1'h0, 16'hffef, 8'h00);
    store(2'h2, 1'h0, 16'h0001, 8'hc4);
  end
  endtask
  task t_beep;
    integer i, c, n, low;
    reg [15:0] got;
  begin
    // Index 6 repeats the first failure to see it sound again
    for (i = 0; i < 7; i = i + 1)
    begin
      fails = 6'h01 << (i % 6);
      got = 16'h0;
      n = 0;
      low = 1;
      for (c = 0; c < 400; c = c + 1)
      begin
        @(negedge clk_sys);
        if (beep && low != 0)
          n = n + 1;
        low = beep ? 0 : low + 1;
        if (low == 9 && n != 0)
        begin
          got = {got[11:0], n[3:0]};
          n = 0;
        end
      end
      chk("beep_code", CODES[16*(i%6) +: 16], got);
      chk("beep_busy", 0, beep_busy);
    end
    fails = 6'h0;
  end
  endtask
  task sys_pulse;
  begin
    sys_reset = 1'h1;
    @(negedge clk_sys);
    sys_reset = 1'h0;
  end
  endtask
  task nmi_try(input [2:0] trig, input en, input on, input [2:0] ev);
    integer c, hi;
    reg [2:0] seen;
  begin
    {wdt_pretimeout, nmi_button, nmi_cmd} = trig;
    wdt_pretimeout_nmi_en = en;
    hi = 0;
    seen = 3'h0;
    for (c = 0; c < 30; c = c + 1)
    begin
      @(negedge clk_sys);
      {wdt_pretimeout, nmi_button, nmi_cmd} = 3'h0;
      if (nmi_out === 1'h1 && hi == 0)
        seen = {event_valid, event_code};
      hi = hi + (nmi_out === 1'h1);
    end
    chk("nmi_long", on, hi >= 10);
    chk("nmi_event", ev, seen);
  end
  endtask
  task t_nmi;
  begin
    nmi_try(3'h1, 1'h0, 1'h1, 3'h0);
    nmi_try(3'h2, 1'h0, 1'h0, 3'h0);
    sys_pulse;
    nmi_try(3'h2, 1'h0, 1'h1, 3'h5);
    sys_pulse;
    nmi_try(3'h4, 1'h0, 1'h0, 3'h0);
    nmi_try(3'h4, 1'h1, 1'h1, 3'h6);
  end
  endtask
  task wdt_hit(input [1:0] kind, input pulse, input [1:0] cnt);
  begin
    wdt_fault = 1'h1;
    wdt_fault_kind = kind;
    @(negedge clk_sys);
    wdt_fault = 1'h0;
    chk("restart", {pulse, kind},
      {restart_pulse, pulse ? restart_kind : kind});
    chk("count", cnt, wdt_reset_count);
    chk("logged", pulse & kind[1], event_valid);
    @(negedge clk_sys);
  end
  endtask
  task t_wdt;
  begin
    wdt_hit(2'h1, 1'h1, 2'h0);
    chk("degraded", 0, status_degraded);
    wdt_hit(2'h3, 1'h1, 2'h1);
    repeat (110) @(negedge clk_sys);
    chk("count", 0, wdt_reset_count);
    chk("degraded", 1, status_degraded);
    wdt_hit(2'h2, 1'h1, 2'h1);
    wdt_hit(2'h3, 1'h1, 2'h2);
    wdt_hit(2'h2, 1'h1, 2'h3);
    wdt_hit(2'h2, 1'h0, 2'h3);
    chk("boot", 1, boot_loader_stage);
    wdt_hit(2'h1, 1'h0, 2'h3);
    sys_pulse;
    @(negedge clk_sys);
    chk("degraded", 0, status_degraded);
  end
  endtask
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst = 1'h0;
    t_time;
    t_store;
    t_beep;
    t_nmi;
    t_wdt;
    tally_and_finish;
  end
endmodule
